// [logic/avg_current_pulse_monitor.sv]
// Pulse-coded monitor of average output current and energization time.
// Notes on behaviour
// - The output repeats a 20 s pulse cycle for as long as constant speed lasts.
// - The averaging window is 0.1 to 1.0 s, default 1 s, and bounds sampling within the start pulse.
// - Current is averaged only while the 1 s start pulse is high.
// - A mask of 0 to 20 s, default 0, delays data collection after constant speed is reached.
// - The reference current of 0 to 500 A is the 100 percent point of the current code.
// - The current pulse lasts the average current times 5 s divided by the reference.
// - The current pulse is clamped to 0.5 s below 10 percent and to 9 s above 180 percent.
// - The current interval is driven low and is followed at once by the maintenance interval driven high.
// - The maintenance pulse lies in 2 to 9 s, 2 s below 16000 h and 9 s above 72000 h.
// - During acceleration or deceleration neither the mask runs nor current is sampled.
// - A speed change during the start pulse discards the data, holds high 3.5 s and then low 16.5 s.
// - After a completed start pulse the cycle is finished even if the speed keeps changing.
// - Function code 93 gives true polarity, 193 inverted, and remote slot seven refuses both.
// - Window, mask and reference settings are taken live while the drive runs.
// - The energization count is in units of 100 h.
module avg_current_pulse_monitor
#(
   parameter int TICK_CYCLES = monitor_pkg::TICK_CYCLES
)
(
   // Clock and reset.
   input wire logic clock,
   input wire logic rst_n,
   // Drive status and measurement.
   input wire logic constant_speed,
   input wire logic [monitor_pkg::AMP_W-1:0] output_current,
   // Settings.
   input wire logic [monitor_pkg::DS_W-1:0] averaging_window,
   input wire logic [monitor_pkg::DS_W-1:0] mask_interval,
   input wire logic [monitor_pkg::REF_W-1:0] reference_current_setting,
   input wire logic [monitor_pkg::HOUR_W-1:0] energization_hour_count,
   input wire logic [monitor_pkg::FUNC_W-1:0] output_function,
   input wire logic [monitor_pkg::FUNC_W-1:0] remote_slot_seven_function,
   // Outputs.
   output logic avg_current_pulse_out,
   output logic open_collector_output,
   output logic remote_slot_seven_reject
);
   localparam int SUM_W = monitor_pkg::AMP_W + 4;
   localparam int NUM_W = SUM_W + monitor_pkg::DS_W;
   localparam int DEN_W = monitor_pkg::REF_W + 4;

   logic rst_meta_n;
   logic rst_sync_n;
   logic const_s;
   logic tick;

   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rst_meta_n <= 1'b0;
         rst_sync_n <= 1'b0;
      end
      else
      begin
         rst_meta_n <= 1'b1;
         rst_sync_n <= rst_meta_n;
      end
   end

   level_sync speed_sync
   (
      .clock(clock),
      .rst_n(rst_sync_n),
      .async_in(constant_speed),
      .level(const_s)
   );

   tick_divider #(.COUNT(TICK_CYCLES)) timebase
   (
      .clock(clock),
      .rst_n(rst_sync_n),
      .tick(tick)
   );

   // Window and mask settings are clamped to their legal ranges so a stray value cannot stall the sequence.
   logic [monitor_pkg::DS_W-1:0] window;
   logic [monitor_pkg::DS_W-1:0] mask;
   always_comb
   begin
      window = averaging_window;
      if (window < monitor_pkg::WINDOW_MIN_DS)
      begin
         window = monitor_pkg::WINDOW_MIN_DS;
      end
      if (window > monitor_pkg::WINDOW_MAX_DS)
      begin
         window = monitor_pkg::WINDOW_MAX_DS;
      end
      mask = mask_interval;
      if (mask > monitor_pkg::MASK_MAX_DS)
      begin
         mask = monitor_pkg::MASK_MAX_DS;
      end
   end

   logic [SUM_W-1:0] sum;
   logic [3:0] samples;
   logic [NUM_W-1:0] numerator;
   logic [DEN_W-1:0] denominator;
   logic [NUM_W-1:0] quotient;
   logic [monitor_pkg::DS_W-1:0] cur_ticks;
   always_comb
   begin
      // Scaling by 5 s is folded into the dividend so one divider serves both the mean and the ratio.
      numerator = NUM_W'(sum * monitor_pkg::CUR_SCALE_DS);
      denominator = DEN_W'(samples * reference_current_setting);
      quotient = '1;
      if (denominator != '0)
      begin
         quotient = numerator / NUM_W'(denominator);
      end
      if (quotient < NUM_W'(monitor_pkg::CUR_MIN_DS))
      begin
         cur_ticks = monitor_pkg::CUR_MIN_DS;
      end
      else if (quotient > NUM_W'(monitor_pkg::CUR_MAX_DS))
      begin
         cur_ticks = monitor_pkg::CUR_MAX_DS;
      end
      else
      begin
         cur_ticks = quotient[monitor_pkg::DS_W-1:0];
      end
   end

   logic [monitor_pkg::HOUR_W-1:0] hour_offset;
   logic [monitor_pkg::DS_W-1:0] maint_ticks;
   always_comb
   begin
      hour_offset = monitor_pkg::HOUR_W'(energization_hour_count - monitor_pkg::MAINT_LOW_COUNT);
      if (energization_hour_count < monitor_pkg::MAINT_LOW_COUNT)
      begin
         maint_ticks = monitor_pkg::MAINT_MIN_DS;
      end
      else if (energization_hour_count > monitor_pkg::MAINT_HIGH_COUNT)
      begin
         maint_ticks = monitor_pkg::MAINT_MAX_DS;
      end
      else
      begin
         maint_ticks = monitor_pkg::DS_W'(monitor_pkg::MAINT_MIN_DS + (hour_offset >> monitor_pkg::MAINT_SLOPE_SHIFT));
      end
   end

   monitor_pkg::state_type state;
   monitor_pkg::state_type next_state;
   logic [monitor_pkg::DS_W-1:0] phase;
   logic [monitor_pkg::DS_W-1:0] next_phase;
   logic [monitor_pkg::DS_W-1:0] cycle;
   logic [monitor_pkg::DS_W-1:0] next_cycle;
   logic [SUM_W-1:0] next_sum;
   logic [3:0] next_samples;
   logic level;
   logic next_level;
   logic sampling;
   logic [monitor_pkg::DS_W-1:0] phase_inc;

   always_comb
   begin
      next_state = state;
      next_phase = phase;
      next_cycle = cycle;
      next_sum = sum;
      next_samples = samples;
      sampling = 1'b0;
      phase_inc = monitor_pkg::DS_W'(phase + 1'b1);
      if (tick)
      begin
         next_cycle = monitor_pkg::DS_W'(cycle + 1'b1);
      end
      case (state)
         monitor_pkg::IDLE:
         begin
            next_phase = '0;
            if (const_s)
            begin
               next_state = (mask == '0) ? monitor_pkg::START : monitor_pkg::MASK;
               next_cycle = '0;
               next_sum = '0;
               next_samples = '0;
            end
         end
         monitor_pkg::MASK:
         begin
            next_cycle = '0;
            if (!const_s)
            begin
               next_state = monitor_pkg::IDLE;
            end
            else if (tick)
            begin
               next_phase = phase_inc;
               if (phase_inc >= mask)
               begin
                  next_state = monitor_pkg::START;
                  next_phase = '0;
               end
            end
         end
         monitor_pkg::START:
         begin
            if (!const_s)
            begin
               next_state = monitor_pkg::BAD_HIGH;
            end
            else if (tick)
            begin
               sampling = (phase < window);
               if (sampling)
               begin
                  next_sum = SUM_W'(sum + output_current);
                  next_samples = 4'(samples + 1'b1);
               end
               next_phase = phase_inc;
               if (phase_inc >= monitor_pkg::START_TIME_DS)
               begin
                  next_state = monitor_pkg::CUR_LOW;
                  next_phase = '0;
               end
            end
         end
         monitor_pkg::CUR_LOW:
         begin
            if (tick)
            begin
               next_phase = phase_inc;
               if (phase_inc >= cur_ticks)
               begin
                  next_state = monitor_pkg::MAINT_HIGH;
                  next_phase = '0;
               end
            end
         end
         monitor_pkg::MAINT_HIGH:
         begin
            if (tick)
            begin
               next_phase = phase_inc;
               if (phase_inc >= maint_ticks)
               begin
                  next_state = monitor_pkg::END_LOW;
                  next_phase = '0;
               end
            end
         end
         monitor_pkg::END_LOW:
         begin
            if (tick && next_cycle >= monitor_pkg::CYCLE_TIME_DS)
            begin
               next_state = const_s ? monitor_pkg::START : monitor_pkg::IDLE;
               next_cycle = '0;
               next_phase = '0;
               next_sum = '0;
               next_samples = '0;
            end
         end
         monitor_pkg::BAD_HIGH:
         begin
            if (tick)
            begin
               next_phase = phase_inc;
               if (phase_inc >= monitor_pkg::INVALID_HIGH_DS)
               begin
                  next_state = monitor_pkg::BAD_LOW;
                  next_phase = '0;
               end
            end
         end
         monitor_pkg::BAD_LOW:
         begin
            if (tick)
            begin
               next_phase = phase_inc;
               if (phase_inc >= monitor_pkg::INVALID_LOW_DS)
               begin
                  next_state = const_s ? monitor_pkg::START : monitor_pkg::IDLE;
                  next_phase = '0;
                  next_cycle = '0;
                  next_sum = '0;
                  next_samples = '0;
               end
            end
         end
         default:
         begin
            next_state = monitor_pkg::IDLE;
         end
      endcase
      next_level = (next_state == monitor_pkg::START) || (next_state == monitor_pkg::MAINT_HIGH)
         || (next_state == monitor_pkg::BAD_HIGH);
   end

   always_ff @(posedge clock or negedge rst_sync_n)
   begin
      if (!rst_sync_n)
      begin
         state <= monitor_pkg::IDLE;
         phase <= '0;
         cycle <= '0;
         sum <= '0;
         samples <= '0;
         level <= 1'b0;
      end
      else
      begin
         state <= next_state;
         phase <= next_phase;
         cycle <= next_cycle;
         sum <= next_sum;
         samples <= next_samples;
         level <= next_level;
      end
   end

   logic next_oc;
   logic next_reject;
   always_comb
   begin
      next_oc = 1'b0;
      if (output_function == monitor_pkg::FUNC_TRUE)
      begin
         next_oc = level;
      end
      else if (output_function == monitor_pkg::FUNC_INVERTED)
      begin
         next_oc = !level;
      end
      next_reject = (remote_slot_seven_function == monitor_pkg::FUNC_TRUE)
         || (remote_slot_seven_function == monitor_pkg::FUNC_INVERTED);
   end

   always_ff @(posedge clock or negedge rst_sync_n)
   begin
      if (!rst_sync_n)
      begin
         avg_current_pulse_out <= 1'b0;
         open_collector_output <= 1'b0;
         remote_slot_seven_reject <= 1'b0;
      end
      else
      begin
         avg_current_pulse_out <= level;
         open_collector_output <= next_oc;
         remote_slot_seven_reject <= next_reject;
      end
   end

   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_sync_n);

   start_high_a: assert property (state == monitor_pkg::START |-> level) else $error("start pulse not high");
   start_len_a: assert property (state == monitor_pkg::START && const_s && tick && phase_inc == monitor_pkg::START_TIME_DS |=> state == monitor_pkg::CUR_LOW) else $error("start pulse length wrong");
   cur_clamp_a: assert property (state == monitor_pkg::CUR_LOW |-> cur_ticks >= monitor_pkg::CUR_MIN_DS && cur_ticks <= monitor_pkg::CUR_MAX_DS) else $error("current pulse out of range");
   maint_clamp_a: assert property (maint_ticks >= monitor_pkg::MAINT_MIN_DS && maint_ticks <= monitor_pkg::MAINT_MAX_DS) else $error("maintenance pulse out of range");
   cur_to_maint_a: assert property (state == monitor_pkg::CUR_LOW ##1 state != monitor_pkg::CUR_LOW |-> state == monitor_pkg::MAINT_HIGH && level) else $error("maintenance high does not follow current low");
   no_sample_a: assert property (!const_s |-> !sampling) else $error("sampled during speed change");
   bad_start_a: assert property (state == monitor_pkg::START && !const_s |=> state == monitor_pkg::BAD_HIGH ##1 level) else $error("invalid start not handled");
   finish_cycle_a: assert property (state == monitor_pkg::CUR_LOW && !const_s |=> state != monitor_pkg::IDLE) else $error("cycle abandoned");
   mask_abort_a: assert property (state == monitor_pkg::MASK && !const_s |=> state == monitor_pkg::IDLE) else $error("mask ran during speed change");
   end_low_a: assert property (state == monitor_pkg::END_LOW |-> !level) else $error("end level not low");
   polarity_a: assert property (output_function == monitor_pkg::FUNC_INVERTED |=> open_collector_output == !$past(level)) else $error("inverted polarity wrong");

   maint_seen_c: cover property (state == monitor_pkg::CUR_LOW ##1 state == monitor_pkg::MAINT_HIGH);
   bad_seen_c: cover property (state == monitor_pkg::BAD_HIGH ##1 state == monitor_pkg::BAD_LOW);
   repeat_c: cover property (state == monitor_pkg::END_LOW ##1 state == monitor_pkg::START);
endmodule

// [logic/level_sync.sv]
// Three-stage synchroniser that passes a change once the last two stages agree.
module level_sync
(
   // Clock and reset.
   input wire logic clock,
   input wire logic rst_n,
   // Asynchronous level in, clean level out.
   input wire logic async_in,
   output logic level
);
   logic stage1;
   logic stage2;
   logic stage3;
   logic next_level;

   always_comb
   begin
      next_level = level;
      if (stage2 == stage3)
      begin
         next_level = stage3;
      end
   end

   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         stage1 <= 1'b0;
         stage2 <= 1'b0;
         stage3 <= 1'b0;
         level <= 1'b0;
      end
      else
      begin
         stage1 <= async_in;
         stage2 <= stage1;
         stage3 <= stage2;
         level <= next_level;
      end
   end
endmodule

// [logic/tick_divider.sv]
// Divider that emits a one-cycle tick every COUNT clock cycles.
module tick_divider
#(
   parameter int COUNT = monitor_pkg::TICK_CYCLES
)
(
   // Clock and reset.
   input wire logic clock,
   input wire logic rst_n,
   // One-cycle pulse.
   output logic tick
);
   localparam int CW = $clog2(COUNT + 1);
   localparam logic [CW-1:0] LAST = CW'(COUNT - 1);
   logic [CW-1:0] count;
   logic [CW-1:0] next_count;
   logic next_tick;

   always_comb
   begin
      next_tick = (count == LAST);
      next_count = next_tick ? '0 : CW'(count + 1'b1);
   end

   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         count <= '0;
         tick <= 1'b0;
      end
      else
      begin
         count <= next_count;
         tick <= next_tick;
      end
   end
endmodule

// [shared/monitor_pkg.sv]
// Constants and types shared by the average current pulse monitor.
package monitor_pkg;
   // Timebase: all segment lengths are counted in ticks of 0.1 s.
   localparam int CLOCK_PERIOD_NS = 5;
   localparam int TICK_TIME_NS = 100000000;
   localparam int TICK_CYCLES = TICK_TIME_NS / CLOCK_PERIOD_NS;
   localparam int DS_W = 8;
   localparam logic [DS_W-1:0] CYCLE_TIME_DS = 8'hC8;
   localparam logic [DS_W-1:0] START_TIME_DS = 8'h0A;
   localparam logic [DS_W-1:0] INVALID_HIGH_DS = 8'h23;
   localparam logic [DS_W-1:0] INVALID_LOW_DS = 8'hA5;
   localparam logic [DS_W-1:0] CUR_MIN_DS = 8'h05;
   localparam logic [DS_W-1:0] CUR_MAX_DS = 8'h5A;
   localparam logic [DS_W-1:0] CUR_SCALE_DS = 8'h32;
   localparam logic [DS_W-1:0] MAINT_MIN_DS = 8'h14;
   localparam logic [DS_W-1:0] MAINT_MAX_DS = 8'h5A;
   localparam logic [DS_W-1:0] WINDOW_MIN_DS = 8'h01;
   localparam logic [DS_W-1:0] WINDOW_MAX_DS = 8'h0A;
   localparam logic [DS_W-1:0] WINDOW_DEFAULT_DS = 8'h0A;
   localparam logic [DS_W-1:0] MASK_MAX_DS = 8'hC8;
   localparam logic [DS_W-1:0] MASK_DEFAULT_DS = 8'h00;
   // Energization count is in units of 100 h.
   localparam int HOUR_W = 14;
   localparam logic [HOUR_W-1:0] MAINT_LOW_COUNT = 14'h00A0;
   localparam logic [HOUR_W-1:0] MAINT_HIGH_COUNT = 14'h02D0;
   localparam int MAINT_SLOPE_SHIFT = 3;
   // Output function codes.
   localparam int FUNC_W = 8;
   localparam logic [FUNC_W-1:0] FUNC_TRUE = 8'h5D;
   localparam logic [FUNC_W-1:0] FUNC_INVERTED = 8'hC1;
   // Current and reference widths in whole amperes.
   localparam int AMP_W = 10;
   localparam int REF_W = 9;
   typedef enum logic [2:0] {IDLE, MASK, START, CUR_LOW, MAINT_HIGH, END_LOW, BAD_HIGH, BAD_LOW} state_type;
endpackage

// [tb/pulse_width_meter.sv]
// Controller input model that measures the width of each level on the monitor line.
module pulse_width_meter
(
   // Clock and reset.
   input wire logic clock,
   input wire logic rst_n,
   // Monitored line.
   input wire logic line,
   // One report per finished level, width in clock cycles.
   output logic seg_done,
   output logic seg_level,
   output int seg_len
);
   timeunit 1ns;
   timeprecision 1ps;
   logic last;
   int count;
   // The line is sampled on the rising edge, as a real input card samples it, so widths are whole cycles.
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         last <= 1'b0;
         count <= 0;
         seg_done <= 1'b0;
         seg_level <= 1'b0;
         seg_len <= 0;
      end
      else
      begin
         seg_done <= 1'b0;
         if (line !== last)
         begin
            seg_done <= 1'b1;
            seg_level <= last;
            seg_len <= count;
            count <= 1;
            last <= line;
         end
         else
         begin
            count <= count + 1;
         end
      end
   end
endmodule

// [tb/tb_avg_current_pulse_monitor.sv]
// Self-checking testbench of the average current pulse monitor.
module tb_avg_current_pulse_monitor;
   timeunit 1ns;
   timeprecision 1ps;
   // A short tick keeps a 20 s cycle at 2000 clocks.
   localparam int TICK = 10;
   logic clock = 1'b0;
   logic rst_n = 1'b0;
   logic constant_speed = 1'b0;
   logic [monitor_pkg::AMP_W-1:0] output_current = 10'h064;
   logic [monitor_pkg::DS_W-1:0] averaging_window = 8'h0A;
   logic [monitor_pkg::DS_W-1:0] mask_interval = 8'h00;
   logic [monitor_pkg::REF_W-1:0] reference_current_setting = 9'h064;
   logic [monitor_pkg::HOUR_W-1:0] energization_hour_count = 14'h0000;
   logic [monitor_pkg::FUNC_W-1:0] output_function = 8'h5D;
   logic [monitor_pkg::FUNC_W-1:0] remote_slot_seven_function = 8'h00;
   logic avg_current_pulse_out;
   logic open_collector_output;
   logic remote_slot_seven_reject;
   logic seg_done;
   logic seg_level;
   int seg_len;
   int n_fail = 0;
   int compares = 0;
   int n;
   logic [7:0] codes [4] = '{8'h5D, 8'hC1, 8'h00, 8'h5C};

   always #2.5 clock = ~clock;

   avg_current_pulse_monitor #(.TICK_CYCLES(TICK)) dut
   (
      .clock(clock),
      .rst_n(rst_n),
      .constant_speed(constant_speed),
      .output_current(output_current),
      .averaging_window(averaging_window),
      .mask_interval(mask_interval),
      .reference_current_setting(reference_current_setting),
      .energization_hour_count(energization_hour_count),
      .output_function(output_function),
      .remote_slot_seven_function(remote_slot_seven_function),
      .avg_current_pulse_out(avg_current_pulse_out),
      .open_collector_output(open_collector_output),
      .remote_slot_seven_reject(remote_slot_seven_reject)
   );

   pulse_width_meter meter
   (
      .clock(clock),
      .rst_n(rst_n),
      .line(open_collector_output),
      .seg_done(seg_done),
      .seg_level(seg_level),
      .seg_len(seg_len)
   );

   task end_of_test;
      $display("comparisons %0d mismatches %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   task check(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp)
      begin
         n_fail++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // Waits for the next finished level; a width of zero ticks means the width is not judged.
   task expect_seg(input logic level, input int ticks);
      int k;
      k = 0;
      do
      begin
         @(negedge clock);
         k++;
      end
      while (seg_done !== 1'b1 && k < 3000);
      check({30'h0, seg_done, seg_level}, {30'h0, 1'b1, level});
      if (ticks > 0)
         check(32'((seg_len + TICK / 2) / TICK), 32'(ticks));
   endtask

   // One whole cycle; the next cycle's inputs are applied during the end level.
   task run_cycle(input int st, input int cur, input int mt, input logic [9:0] na, input logic [8:0] nr,
                  input logic [13:0] nh);
      expect_seg(1'b1, st);
      expect_seg(1'b0, cur);
      expect_seg(1'b1, mt);
      output_current = na;
      reference_current_setting = nr;
      energization_hour_count = nh;
      expect_seg(1'b0, (st > 0) ? 190 - cur - mt : 0);
      $display("cycle done at %0t", $time);
   endtask

   initial
   begin
      repeat (20) @(negedge clock);
      rst_n = 1'b1;
      repeat (8) @(negedge clock);
      foreach (codes[i])
      begin
         output_function = codes[i];
         remote_slot_seven_function = codes[i];
         repeat (4) @(negedge clock);
         check({31'h0, remote_slot_seven_reject}, {31'h0, codes[i] == 8'h5D || codes[i] == 8'hC1});
         check({31'h0, open_collector_output}, {31'h0, codes[i] == 8'hC1});
      end
      output_function = 8'h5D;
      repeat (4) @(negedge clock);
      $display("routing test done");
      mask_interval = 8'h1E;
      constant_speed = 1'b1;
      repeat (15 * TICK) @(negedge clock);
      constant_speed = 1'b0;
      repeat (5 * TICK) @(negedge clock);
      constant_speed = 1'b1;
      n = 0;
      while (avg_current_pulse_out !== 1'b1 && n < 2000)
      begin
         @(negedge clock);
         n++;
      end
      check(32'(n >= 29 * TICK && n < 32 * TICK), 32'h1);
      mask_interval = 8'h00;
      expect_seg(1'b0, 0);
      $display("mask test done");
      run_cycle(0, 50, 20, 10'h005, 9'h064, 14'h00A0);
      run_cycle(10, 5, 20, 10'h0C8, 9'h064, 14'h02D0);
      run_cycle(10, 90, 90, 10'h025, 9'h064, 14'h0190);
      run_cycle(10, 18, 50, 10'h064, 9'h000, 14'h03E8);
      averaging_window = 8'h01;
      run_cycle(10, 90, 90, 10'h064, 9'h064, 14'h0000);
      // Only the first sample may count with the shortest window, so a later jump leaves the code alone.
      repeat (3 * TICK) @(negedge clock);
      output_current = 10'h190;
      run_cycle(10, 50, 20, 10'h064, 9'h064, 14'h0000);
      repeat (3 * TICK) @(negedge clock);
      constant_speed = 1'b0;
      expect_seg(1'b1, 35);
      constant_speed = 1'b1;
      expect_seg(1'b0, 165);
      $display("discard test done");
      expect_seg(1'b1, 10);
      constant_speed = 1'b0;
      expect_seg(1'b0, 50);
      expect_seg(1'b1, 20);
      // With the speed still changing no start pulse follows, so the end level can only be watched, not timed.
      n = 0;
      repeat (120 * TICK)
      begin
         @(negedge clock);
         if (open_collector_output !== 1'b0)
            n++;
      end
      check(32'(n), 32'h0);
      check({31'h0, seg_done}, 32'h0);
      n = 0;
      repeat (300 * TICK)
      begin
         @(negedge clock);
         if (avg_current_pulse_out !== 1'b0)
            n++;
      end
      check(32'(n), 32'h0);
      $display("finish test done");
      end_of_test();
   end

   initial
   begin
      repeat (40000) @(posedge clock);
      n_fail++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, 32'h0, 32'h1);
      end_of_test();
   end
endmodule
